// >>> rerl_defines.vh
// constants for the recoverable error report logger
// assumes inclusion by bare name from the logger design files
`ifndef RERL_DEFINES_VH
`define RERL_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define RERL_OFF_CTRL      8'h00
`define RERL_OFF_BANK_SEL  8'h04
`define RERL_OFF_LP_SEL    8'h08
`define RERL_OFF_STAT_LO   8'h0C
`define RERL_OFF_STAT_HI   8'h10
`define RERL_OFF_ADDR_LO   8'h14
`define RERL_OFF_ADDR_HI   8'h18
`define RERL_OFF_EXTRA     8'h1C
`define RERL_OFF_GLOBAL    8'h20

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define RERL_CTRL_LOCAL_EN  0
`define RERL_CTRL_AO_INTR   1
`define RERL_CTRL_EN_INTR   2
`define RERL_CTRL_RESET     3'h0

// ----------------------------------------------------------------
// bank_error_status upper word flag positions (bits 63..55)
// ----------------------------------------------------------------
`define RERL_ST_VAL   31
`define RERL_ST_OVER  30
`define RERL_ST_UNCORR  29
`define RERL_ST_EN      28
`define RERL_ST_EXTRA_V 27
`define RERL_ST_LOC_V   26
`define RERL_ST_CTX_BAD 25
`define RERL_ST_S       24
`define RERL_ST_ACT_REQ 23

// ----------------------------------------------------------------
// global_check_status fields
// ----------------------------------------------------------------
`define RERL_GS_RESTART_V 0
`define RERL_GS_ERRPTR_V  1
`define RERL_GS_MCIP  2
`define RERL_GS_LOCAL 3

// ----------------------------------------------------------------
// error kinds and error code subfields
// ----------------------------------------------------------------
`define RERL_KIND_SCRUB 2'h0
`define RERL_KIND_WB    2'h1
`define RERL_KIND_LOAD  2'h2
`define RERL_KIND_FETCH 2'h3
`define RERL_MEM_PREFIX   9'h001
`define RERL_CACHE_PREFIX 8'h01
`define RERL_MEMOP_SCRUB  3'h4
`define RERL_CHAN_GENERIC 4'hF
`define RERL_REQ_EVICT    4'h7
`define RERL_REQ_DATA_RD  4'h3
`define RERL_REQ_INSTR_RD 4'h5
`define RERL_XACT_INSTR   2'h0
`define RERL_XACT_DATA    2'h1
`define RERL_XACT_GENERIC 2'h2
`define RERL_LEVEL_0      2'h0
`define RERL_LEVEL_2      2'h2

// ----------------------------------------------------------------
// bank_extra_info fields
// ----------------------------------------------------------------
`define RERL_MISC_MODE_PHYS 3'h2
`define RERL_MISC_LSB_W     6

`endif

// >>> rerl_addr_mem.v
// per-bank store of fault location and lowest valid address bit
// assumes one clock; read data registered every cycle
`default_nettype none

module rerl_addr_mem #(
  parameter WIDTH  = 58,
  parameter DEPTH  = 4,
  parameter IDX_W  = 2
) (
  // clock
  input  wire             core_clk,
  // write port
  input  wire             wr_en,
  input  wire [IDX_W-1:0] wr_idx,
  input  wire [WIDTH-1:0] wr_data,
  // read port
  input  wire [IDX_W-1:0] rd_idx,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] store [0:DEPTH-1];

  always @(posedge core_clk) begin
    if (wr_en) begin
      store[wr_idx] <= wr_data;
    end
    rd_data <= store[rd_idx];
  end

endmodule
`default_nettype wire

// >>> rerl_logger.v
// recoverable uncorrected error logger: error codes, bank status, globals
// assumes error events synchronous to core_clk, one at a time under ready
`default_nettype none
`include "rerl_defines.vh"

module rerl_logger #(
  parameter NUM_LP          = 4,
  parameter LP_W            = 2,
  parameter NUM_BANKS       = 4,
  parameter BANK_W          = 2,
  parameter ADDR_W          = 52,
  parameter LOCAL_SUPPORTED = 1
) (
  // clock and reset
  input  wire                 core_clk,
  input  wire                 reset,
  // register port
  input  wire [7:0]           reg_addr,
  input  wire [31:0]          reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [31:0]          reg_rdata,
  // error event
  input  wire                 err_valid,
  output wire                 err_ready,
  input  wire [1:0]           err_kind,
  input  wire [3:0]           err_channel,
  input  wire                 err_channel_known,
  input  wire [ADDR_W-1:0]    err_addr,
  input  wire [5:0]           err_addr_lsb,
  input  wire [BANK_W-1:0]    err_bank,
  input  wire [LP_W-1:0]      err_lp,
  input  wire                 err_continuable,
  input  wire                 err_pointer_hint,
  input  wire                 err_local_req,
  // signalling
  output reg  [NUM_LP-1:0]    machine_check_exception,
  output reg                  corrected_error_interrupt
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_LOG    = 3'b010;
  localparam [2:0] ST_SIGNAL = 3'b100;
  localparam MEM_W = ADDR_W + `RERL_MISC_LSB_W;

  reg [2:0]          state;
  reg [2:0]          next_state;
  reg [2:0]          ctrl;
  reg [BANK_W-1:0]   bank_sel;
  reg [LP_W-1:0]     lp_sel;
  reg [1:0]          hold_kind;
  reg [3:0]          hold_channel;
  reg [ADDR_W-1:0]   hold_addr;
  reg [5:0]          hold_lsb;
  reg [BANK_W-1:0]   hold_bank;
  reg [LP_W-1:0]     hold_lp;
  reg                hold_cont;
  reg                hold_hint;
  reg                hold_local;
  reg                hold_intr;
  reg                hold_en_intr;
  reg [8:0]          bank_flags [0:NUM_BANKS-1];
  reg [15:0]         bank_code  [0:NUM_BANKS-1];
  reg [3:0]          gstat      [0:NUM_LP-1];
  reg [1:0]          rd_src;
  reg [31:0]         rd_q;
  wire [MEM_W-1:0]   mem_q;
  wire [63:0]        addr_ext;
  integer            i;
  integer            j;

  // ----------------------------------------------------------------
  // error code and status forming
  // ----------------------------------------------------------------
  function [15:0] err_code;
    input [1:0] kind;
    input [3:0] chan;
    begin
      case (kind)
        `RERL_KIND_SCRUB: err_code = {`RERL_MEM_PREFIX, `RERL_MEMOP_SCRUB, chan};
        `RERL_KIND_WB:    err_code = {`RERL_CACHE_PREFIX, `RERL_REQ_EVICT,
                                      `RERL_XACT_GENERIC, `RERL_LEVEL_2};
        `RERL_KIND_LOAD:  err_code = {`RERL_CACHE_PREFIX, `RERL_REQ_DATA_RD,
                                      `RERL_XACT_DATA, `RERL_LEVEL_0};
        default:          err_code = {`RERL_CACHE_PREFIX, `RERL_REQ_INSTR_RD,
                                      `RERL_XACT_INSTR, `RERL_LEVEL_0};
      endcase
    end
  endfunction

  // flags: valid, overflow, uncorrected, enable, info, location, corrupt, signalled, action
  function [8:0] err_flags;
    input       required;
    input       via_intr;
    input       en_intr;
    reg         en;
    reg         sig;
    begin
      en  = required | ~via_intr | en_intr;
      sig = required | ~via_intr;
      err_flags = {1'b1, 1'b0, 1'b1, en, 1'b1, 1'b1, 1'b0, sig, required};
    end
  endfunction

  assign err_ready = (state == ST_IDLE);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always @* begin
    case (state)
      ST_IDLE:   next_state = err_valid ? ST_LOG : ST_IDLE;
      ST_LOG:    next_state = ST_SIGNAL;
      ST_SIGNAL: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      state        <= ST_IDLE;
      hold_kind    <= 2'h0;
      hold_channel <= 4'h0;
      hold_addr    <= {ADDR_W{1'b0}};
      hold_lsb     <= 6'h00;
      hold_bank    <= {BANK_W{1'b0}};
      hold_lp      <= {LP_W{1'b0}};
      hold_cont    <= 1'b0;
      hold_hint    <= 1'b0;
      hold_local   <= 1'b0;
      hold_intr    <= 1'b0;
      hold_en_intr <= 1'b0;
      machine_check_exception   <= {NUM_LP{1'b0}};
      corrected_error_interrupt <= 1'b0;
    end else begin
      state <= next_state;
      machine_check_exception   <= {NUM_LP{1'b0}};
      corrected_error_interrupt <= 1'b0;
      if (state == ST_IDLE && err_valid) begin
        hold_kind    <= err_kind;
        hold_channel <= err_channel_known ? err_channel : `RERL_CHAN_GENERIC;
        hold_addr    <= err_addr;
        hold_lsb     <= err_addr_lsb;
        hold_bank    <= err_bank;
        hold_lp      <= err_lp;
        hold_cont    <= err_continuable;
        hold_hint    <= err_pointer_hint;
        hold_local   <= (LOCAL_SUPPORTED != 0) & ctrl[`RERL_CTRL_LOCAL_EN] & err_local_req;
        hold_intr    <= ~err_kind[1] & ctrl[`RERL_CTRL_AO_INTR];
        hold_en_intr <= ctrl[`RERL_CTRL_EN_INTR];
      end
      if (state == ST_SIGNAL) begin
        if (hold_intr) begin
          corrected_error_interrupt <= 1'b1;
        end else if (hold_local) begin
          for (j = 0; j < NUM_LP; j = j + 1) begin
            machine_check_exception[j] <= (j == hold_lp);
          end
        end else begin
          machine_check_exception <= {NUM_LP{1'b1}};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // bank records and global status
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      for (i = 0; i < NUM_BANKS; i = i + 1) begin
        bank_flags[i] <= 9'h000;
        bank_code[i]  <= 16'h0000;
      end
      for (i = 0; i < NUM_LP; i = i + 1) begin
        gstat[i] <= 4'h0;
      end
    end else begin
      if (reg_wr && reg_addr == `RERL_OFF_STAT_HI) begin
        bank_flags[bank_sel] <= 9'h000;
      end
      if (reg_wr && reg_addr == `RERL_OFF_GLOBAL) begin
        gstat[lp_sel] <= gstat[lp_sel] & reg_wdata[3:0];
      end
      // logging comes last so that a new record wins over a clear
      if (state == ST_LOG) begin
        bank_code[hold_bank]  <= err_code(hold_kind, hold_channel);
        bank_flags[hold_bank] <= err_flags(hold_kind[1], hold_intr, hold_en_intr);
        if (!hold_intr) begin
          for (i = 0; i < NUM_LP; i = i + 1) begin
            if (!hold_local || i == hold_lp) begin
              if (hold_kind[1] && i == hold_lp) begin
                gstat[i][`RERL_GS_RESTART_V] <= hold_cont;
                gstat[i][`RERL_GS_ERRPTR_V]  <= hold_cont | hold_hint;
              end else begin
                gstat[i][`RERL_GS_RESTART_V] <= 1'b1;
                gstat[i][`RERL_GS_ERRPTR_V]  <= 1'b0;
              end
              gstat[i][`RERL_GS_MCIP]  <= 1'b1;
              gstat[i][`RERL_GS_LOCAL] <= hold_local;
            end
          end
        end
      end
    end
  end

  rerl_addr_mem #(
    .WIDTH (MEM_W),
    .DEPTH (NUM_BANKS),
    .IDX_W (BANK_W)
  ) u_addr_mem (
    .core_clk (core_clk),
    .wr_en    (state == ST_LOG),
    .wr_idx   (hold_bank),
    .wr_data  ({hold_addr, hold_lsb}),
    .rd_idx   (bank_sel),
    .rd_data  (mem_q)
  );

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      ctrl     <= `RERL_CTRL_RESET;
      bank_sel <= {BANK_W{1'b0}};
      lp_sel   <= {LP_W{1'b0}};
    end else if (reg_wr) begin
      case (reg_addr)
        `RERL_OFF_CTRL:     ctrl     <= reg_wdata[2:0];
        `RERL_OFF_BANK_SEL: bank_sel <= reg_wdata[BANK_W-1:0];
        `RERL_OFF_LP_SEL:   lp_sel   <= reg_wdata[LP_W-1:0];
        default:            ctrl     <= ctrl;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      rd_src <= 2'h0;
      rd_q   <= 32'h00000000;
    end else begin
      rd_src <= 2'h0;
      rd_q   <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `RERL_OFF_CTRL:     rd_q <= {29'h0, ctrl};
          `RERL_OFF_BANK_SEL: rd_q <= {{(32-BANK_W){1'b0}}, bank_sel};
          `RERL_OFF_LP_SEL:   rd_q <= {{(32-LP_W){1'b0}}, lp_sel};
          `RERL_OFF_STAT_LO:  rd_q <= {16'h0000, bank_code[bank_sel]};
          `RERL_OFF_STAT_HI:  rd_q <= {bank_flags[bank_sel], 23'h0};
          `RERL_OFF_GLOBAL:   rd_q <= {28'h0000000, gstat[lp_sel]};
          `RERL_OFF_ADDR_LO:  rd_src <= 2'h1;
          `RERL_OFF_ADDR_HI:  rd_src <= 2'h2;
          `RERL_OFF_EXTRA:    rd_src <= 2'h3;
          default:            rd_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign addr_ext = {{(64-ADDR_W){1'b0}}, mem_q[MEM_W-1:`RERL_MISC_LSB_W]};

  always @* begin
    case (rd_src)
      2'h1:    reg_rdata = addr_ext[31:0];
      2'h2:    reg_rdata = addr_ext[63:32];
      2'h3:    reg_rdata = {23'h0, `RERL_MISC_MODE_PHYS, mem_q[5:0]};
      default: reg_rdata = rd_q;
    endcase
  end

endmodule
`default_nettype wire

// >>> rerl_logger_assertions.sv
// checker for event handshake and delivery pulses of the error logger
// assumes bind onto rerl_logger, one clock, sync reset
`default_nettype none
module rerl_logger_assertions #(
  parameter NUM_LP = 4
) (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              reset,
  // error event
  input wire logic              err_valid,
  input wire logic              err_ready,
  input wire logic [1:0]        err_kind,
  input wire logic              err_local_req,
  // signalling
  input wire logic [NUM_LP-1:0] machine_check_exception,
  input wire logic              corrected_error_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  logic any;
  assign take = err_valid && err_ready;
  assign any = |machine_check_exception || corrected_error_interrupt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ready_drop: assert property (take |=> !err_ready ##1 !err_ready ##1 err_ready)
    else $error("ready timing wrong");
  a_signal_delay: assert property (take |-> ##3 any)
    else $error("no delivery three cycles after event");
  a_no_stray: assert property (any |-> $past(take, 3))
    else $error("delivery without event");
  a_pulse_single: assert property (|machine_check_exception |=> machine_check_exception == '0)
    else $error("exception pulse too long");
  a_required_exc: assert property (take && err_kind[1] |-> ##3 (|machine_check_exception && !corrected_error_interrupt))
    else $error("required error not an exception");
  a_required_bcast: assert property (take && err_kind[1] && !err_local_req |-> ##3 &machine_check_exception)
    else $error("required error not broadcast");
  a_local_single: assert property (take && err_local_req |-> ##3
      ($onehot(machine_check_exception) || &machine_check_exception || corrected_error_interrupt))
    else $error("local delivery mask wrong");
  a_intr_optional: assert property (corrected_error_interrupt |-> $past(err_kind, 3) < 2'h2)
    else $error("interrupt for required error");
  a_one_path: assert property (!(corrected_error_interrupt && |machine_check_exception))
    else $error("both signalling paths at once");
  c_fetch: cover property (take && err_kind == 2'h3);
  c_intr: cover property (corrected_error_interrupt);
  c_local: cover property (take && err_local_req);
endmodule
bind rerl_logger rerl_logger_assertions #(.NUM_LP(NUM_LP)) i_rerl_chk (
  .core_clk(core_clk), .reset(reset), .err_valid(err_valid), .err_ready(err_ready),
  .err_kind(err_kind), .err_local_req(err_local_req), .machine_check_exception(machine_check_exception),
  .corrected_error_interrupt(corrected_error_interrupt));
`default_nettype wire

// >>> rerl_handler_model.sv
// handler model: tallies exception and interrupt deliveries
// assumes one-cycle pulses on core_clk
`default_nettype none
module rerl_handler_model #(
  parameter NUM_LP = 4
) (
  // clock
  input  wire logic              core_clk,
  // deliveries
  input  wire logic [NUM_LP-1:0] exc,
  input  wire logic              cei,
  // tallies
  output var  int                n_exc,
  output var  int                n_cei
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    n_exc = 0;
    n_cei = 0;
  end
  always @(posedge core_clk) begin
    n_exc <= n_exc + $countones(exc);
    n_cei <= n_cei + 32'(cei);
  end
endmodule
`default_nettype wire

// >>> rerl_logger_tb_top.sv
// self-checking bench for the error logger
// assumes default parameters: four processors, four banks
`default_nettype none
`include "rerl_defines.vh"
module rerl_logger_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, err_valid = 0, rd_d = 0;
  logic        err_channel_known = 0, err_continuable = 0, err_pointer_hint = 0, err_local_req = 0;
  logic        err_ready, cei;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [1:0]  err_kind = 0, err_bank = 0, err_lp = 0;
  logic [3:0]  err_channel = 0, exc;
  logic [51:0] err_addr = 0;
  logic [5:0]  err_addr_lsb = 0;
  logic [63:0] rx;
  logic [31:0] last_rd;
  logic [63:0] rd_q[$];
  logic [4:0]  ev_q[$];
  int          fails = 0, comparisons = 0, cycles = 0, exp_exc = 0, exp_cei = 0, n_exc, n_cei;
  integer      seed = 32'h06F91025;
  rerl_logger i_dut (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_valid(err_valid), .err_ready(err_ready), .err_kind(err_kind),
    .err_channel(err_channel), .err_channel_known(err_channel_known), .err_addr(err_addr),
    .err_addr_lsb(err_addr_lsb), .err_bank(err_bank), .err_lp(err_lp), .err_continuable(err_continuable),
    .err_pointer_hint(err_pointer_hint), .err_local_req(err_local_req), .machine_check_exception(exc),
    .corrected_error_interrupt(cei));
  rerl_handler_model #(.NUM_LP(4)) i_handler (.core_clk(core_clk), .exc(exc), .cei(cei), .n_exc(n_exc),
    .n_cei(n_cei));
  initial forever #5 core_clk = ~core_clk;
  task automatic give_verdict;
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // handler decision: resume only with restart valid and the fault fixed
  function automatic logic handler_resumes(input logic restart_ok, input logic fixed);
    return restart_ok && fixed;
  endfunction
  task automatic chk(input string what, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    rd_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  // ----------------------------------------------------------------
  // one random event of kind k, then full readback
  // ----------------------------------------------------------------
  task automatic log_one(input logic [1:0] k);
    logic [31:0] r, r2, g;
    logic [15:0] code;
    logic [3:0]  dm;
    logic [51:0] a;
    logic        via_intr, lcl;
    r = $random(seed);
    r2 = $random(seed);
    a = {r[31:12], r2};
    lcl = r[11] && r[20];
    via_intr = !k[1] && r[21];
    dm = via_intr ? 4'h0 : lcl ? 4'h1 << r[8:7] : 4'hF;
    code = k == 2'h0 ? {12'h00C, r[4] ? r[3:0] : 4'hF} : k == 2'h1 ? 16'h017A : k == 2'h2 ? 16'h0134 : 16'h0150;
    wr(`RERL_OFF_CTRL, {29'h0, r[22:20]});
    for (int i = 0; i < 4; i++) begin
      wr(`RERL_OFF_LP_SEL, 32'(i));
      wr(`RERL_OFF_GLOBAL, 32'h0);
    end
    ev_q.push_back({via_intr, dm});
    exp_exc += $countones(dm);
    exp_cei += 32'(via_intr);
    err_kind <= k;
    err_channel <= r[3:0];
    err_channel_known <= r[4];
    err_bank <= r[6:5];
    err_lp <= r[8:7];
    err_continuable <= r[9];
    err_pointer_hint <= r[10];
    err_local_req <= r[11];
    err_addr_lsb <= r[17:12];
    err_addr <= a;
    err_valid <= 1'b1;
    @(posedge core_clk);
    err_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    wr(`RERL_OFF_BANK_SEL, {30'h0, r[6:5]});
    rd(`RERL_OFF_STAT_LO, {16'h0, code}, 32'hFFFF_EFFF);
    rd(`RERL_OFF_STAT_HI, {3'h5, via_intr ? r[22] : 1'b1, 3'h6, !via_intr, k[1], 23'h0}, '1);
    rd(`RERL_OFF_ADDR_LO, a[31:0], 32'hFFFF_FFFF);
    rd(`RERL_OFF_ADDR_HI, {12'h0, a[51:32]}, 32'hFFFF_FFFF);
    rd(`RERL_OFF_EXTRA, {23'h0, 3'h2, r[17:12]}, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) begin
      g = 32'h0;
      if (dm[i])
        g = (k[1] && i == r[8:7]) ? {28'h0, lcl, 1'b1, r[9] | r[10], r[9]} : {28'h0, lcl, 3'h5};
      wr(`RERL_OFF_LP_SEL, 32'(i));
      rd(`RERL_OFF_GLOBAL, g, 32'hFFFF_FFFF);
      if (k[1] && i == r[8:7])
        chk("resume", 32'(r[9] && r[23]), 32'(handler_resumes(last_rd[0], r[23])));
    end
  endtask
  // ----------------------------------------------------------------
  // output watcher
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    cycles++;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end
  always @(negedge core_clk) begin
    if (rd_d) begin
      rx = rd_q.pop_front();
      last_rd = reg_rdata;
      chk("read data", rx[31:0], reg_rdata & rx[63:32]);
    end
    if (|exc || cei)
      chk("delivery", 32'(ev_q.pop_front()), {27'h0, cei, exc});
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(`RERL_OFF_CTRL, 32'h0, 32'hFFFF_FFFF);
    rd(`RERL_OFF_GLOBAL, 32'h0, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, 32'hFFFF_FFFF);
    for (int n = 0; n < 24; n++)
      log_one(2'(n));
    wr(`RERL_OFF_STAT_HI, 32'h0);
    rd(`RERL_OFF_STAT_HI, 32'h0, 32'hFFFF_FFFF);
    repeat (4) @(posedge core_clk);
    chk("exception count", 32'(exp_exc), 32'(n_exc));
    chk("interrupt count", 32'(exp_cei), 32'(n_cei));
    give_verdict();
  end
endmodule
`default_nettype wire
